/* rtl/door_lock_map.svh */
`ifndef DOOR_LOCK_MAP_SVH
`define DOOR_LOCK_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define TICK_PERIOD_NS   1000000
`define TICK_CYCLES      (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define KEY_A_HOLD_MS    1000
`define FALLBACK_WIN_MS  5000
`define RELOCK_MS        60000
`define INTERIOR_DLY_MS  30000
`define FLASH_MS         500
`define TICK_MS          1
`define KEY_A_HOLD_TICKS  (`KEY_A_HOLD_MS / `TICK_MS)
`define FALLBACK_TICKS    (`FALLBACK_WIN_MS / `TICK_MS)
`define RELOCK_TICKS      (`RELOCK_MS / `TICK_MS)
`define INTERIOR_TICKS    (`INTERIOR_DLY_MS / `TICK_MS)
`define FLASH_TICKS       (`FLASH_MS / `TICK_MS)
`define SPEED_LOCK_KMH   8'h0E

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define CTRL_RESET       32'h0000_0001
`define CTRL_SPEED_BIT   0
`define CTRL_CABRIO_BIT  1
`define ST_DRV_LOCKED    0
`define ST_PAS_LOCKED    1
`define ST_FLAP_LOCKED   2
`define ST_REAR_EN       3
`define ST_ARMED         4
`define ST_ALARM         5
`define ST_KEY_A         6
`define ST_INTERIOR_LIVE 7
`define ST_EXCLUDED      8
`define ST_FALLBACK_LSB  9

`endif

/* rtl/door_lock_pkg.sv */
package door_lock_pkg;

  typedef struct packed {
    logic auth;
    logic lock;
    logic unlock;
    logic rear;
    logic top;
    logic key_a;
  } fob_type;

  typedef struct packed {
    logic door_l_open;
    logic door_r_open;
    logic rear_open;
    logic handle_l;
    logic handle_r;
    logic rear_handle;
    logic trunk_latch;
  } door_in_type;

  typedef struct packed {
    logic lock_all;
    logic unlock_drv;
    logic unlock_pas;
    logic unlock_flap;
    logic trunk_release;
    logic top_open;
  } act_type;

  typedef struct packed {
    logic drv;
    logic pas;
    logic flap;
    logic rear_en;
  } lock_state_type;

  typedef enum logic [1:0] {
    FB_IDLE = 2'b00,
    FB_SEEN = 2'b01,
    FB_WAIT = 2'b11
  } fallback_type;

endpackage : door_lock_pkg

/* rtl/tick_timer.sv */
`timescale 1ns/1ps
module tick_timer #(
  parameter logic [15:0] LIMIT = 16'h0001
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic run,
  output logic      done
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (!run) begin
      cnt_q <= 16'h0000;
    end else if (tick && cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // done comes from the count alone, so a user may gate run with done without a loop
  assign done = (cnt_q == LIMIT);
endmodule : tick_timer

/* rtl/door_lock_alarm_ctrl.sv */
`timescale 1ns/1ps
`include "door_lock_map.svh"
// How it works
// - key_a held one second starts siren and flashing turn lamps.
// - key_a stops on ignition switched on or a new key_a press.
// - cockpit switch with all doors shut locks/unlocks all, rear handle follows.
// - door open, ignition on, lock switch; ignition off in 5 s, door shut locks.
// - mechanical key unlocks driver door; flap only with good supply.
// - mechanical unlock while armed raises the alarm.
// - ignition on and speed over 14 km/h locks, if enabled.
// - unlock with no door opened for 60 s relocks.
// - crash signal unlocks the doors.
// - coupe: authorized fob rear request drives trunk latch; others ignored.
// - cabrio: authorized fob top request drives soft-top motor; others ignored.
// - armed and any monitored input changes raises siren and lamps.
// - fob lock arms theft_alarm; fob unlock disarms it.
// - authorized key present plus ignition on disarms.
// - interior sensor watched only 30 s after locking.
// - exclusion switch drops interior and tilt watching this cycle.
// - exclusion cancelled at next vehicle lock.
// - first fob unlock: driver and flap, flash; second: passenger, rear, flash.
// - rear handle only while globally unlocked; then releases trunk latch.
// - inside handle unlocks its own door and flap, whatever the state.
module door_lock_alarm_ctrl #(
  parameter int TICK_DIV = `TICK_CYCLES
) (
  input  wire logic                     REF_CLK,
  input  wire logic                     RESETN,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [11:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  input  wire logic [3:0]               PSTRB,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire door_lock_pkg::fob_type     FOB,
  input  wire door_lock_pkg::door_in_type DOORS,
  input  wire logic                     LOCK_SW,
  input  wire logic                     UNLOCK_SW,
  input  wire logic                     EXCLUDE_SW,
  input  wire logic                     MECH_KEY,
  input  wire logic                     KEY_PRESENT,
  input  wire logic                     IGN_RUN,
  input  wire logic                     CRASH,
  input  wire logic                     SUPPLY_OK,
  input  wire logic [7:0]               SPEED_KMH,
  input  wire logic                     INTERIOR,
  input  wire logic                     TILT,
  output door_lock_pkg::act_type          ACT,
  output logic                          SIREN,
  output logic                          TURN_LAMP
);
  import door_lock_pkg::*;

  // ----------------------------------------------------------------
  // tick and timers
  // ----------------------------------------------------------------
  localparam int NTMR = 5;
  localparam int T_KEY_A = 0;
  localparam int T_FB = 1;
  localparam int T_RELOCK = 2;
  localparam int T_INT = 3;
  localparam int T_FLASH = 4;
  localparam logic [15:0] LIMITS [NTMR] = '{
    16'(`KEY_A_HOLD_TICKS), 16'(`FALLBACK_TICKS), 16'(`RELOCK_TICKS),
    16'(`INTERIOR_TICKS), 16'(`FLASH_TICKS)};

  logic [31:0]     div_q;
  logic            tick;
  logic [NTMR-1:0] run;
  logic [NTMR-1:0] done;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_q <= 32'h0000_0000;
    end else if (div_q >= 32'(TICK_DIV - 1)) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end
  assign tick = (div_q >= 32'(TICK_DIV - 1));

  generate
    for (genvar i = 0; i < NTMR; i++) begin : g_tmr
      tick_timer #(
        .LIMIT (LIMITS[i])
      ) u_tmr (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tick  (tick),
        .run   (run[i]),
        .done  (done[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  fob_type        fob_q;
  door_in_type    doors_q;
  logic           lock_sw_q;
  logic           unlock_sw_q;
  logic           excl_sw_q;
  logic           mech_q;
  logic           ign_q;
  logic           crash_q;
  logic           spd_q;
  logic           interior_q;
  logic           tilt_q;
  logic           spd_cond;

  assign spd_cond = IGN_RUN && (SPEED_KMH > `SPEED_LOCK_KMH);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fob_q       <= '0;
      doors_q     <= '0;
      lock_sw_q   <= 1'b0;
      unlock_sw_q <= 1'b0;
      excl_sw_q   <= 1'b0;
      mech_q      <= 1'b0;
      ign_q       <= 1'b0;
      crash_q     <= 1'b0;
      spd_q       <= 1'b0;
      interior_q  <= 1'b0;
      tilt_q      <= 1'b0;
    end else begin
      fob_q       <= FOB;
      doors_q     <= DOORS;
      lock_sw_q   <= LOCK_SW;
      unlock_sw_q <= UNLOCK_SW;
      excl_sw_q   <= EXCLUDE_SW;
      mech_q      <= MECH_KEY;
      ign_q       <= IGN_RUN;
      crash_q     <= CRASH;
      spd_q       <= spd_cond;
      interior_q  <= INTERIOR;
      tilt_q      <= TILT;
    end
  end

  logic fob_lock_ev, fob_unlock_ev, fob_rear_ev, fob_top_ev, key_a_ev;
  logic cockpit_lock_ev, cockpit_unlock_ev, all_closed, any_open, ign_on_ev;
  logic mech_ev, crash_ev, speed_ev, excl_ev, rear_handle_ev;
  logic handle_l_ev, handle_r_ev;

  assign fob_lock_ev    = FOB.auth && FOB.lock && !fob_q.lock;
  assign fob_unlock_ev  = FOB.auth && FOB.unlock && !fob_q.unlock;
  assign fob_rear_ev    = FOB.auth && FOB.rear && !fob_q.rear;
  assign fob_top_ev     = FOB.auth && FOB.top && !fob_q.top;
  assign key_a_ev       = FOB.key_a && !fob_q.key_a;
  assign all_closed     = !DOORS.door_l_open && !DOORS.door_r_open && !DOORS.rear_open;
  assign any_open       = DOORS.door_l_open || DOORS.door_r_open || DOORS.rear_open;
  assign cockpit_lock_ev   = LOCK_SW && !lock_sw_q;
  assign cockpit_unlock_ev = UNLOCK_SW && !unlock_sw_q;
  assign ign_on_ev      = IGN_RUN && !ign_q;
  assign mech_ev        = MECH_KEY && !mech_q;
  assign crash_ev       = CRASH && !crash_q;
  assign speed_ev       = spd_cond && !spd_q;
  assign excl_ev        = EXCLUDE_SW && !excl_sw_q;
  assign rear_handle_ev = DOORS.rear_handle && !doors_q.rear_handle;
  assign handle_l_ev    = DOORS.handle_l && !doors_q.handle_l;
  assign handle_r_ev    = DOORS.handle_r && !doors_q.handle_r;

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic        apb_wr;
  logic        addr_ok;

  assign addr_ok = (PADDR == `REG_CTRL) || (PADDR == `REG_STATUS);
  assign apb_wr  = PSEL && PENABLE && PWRITE && (PADDR == `REG_CTRL);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= `CTRL_RESET;
    end else if (apb_wr && PSTRB[0]) begin
      ctrl_q <= {30'h0000_0000, PWDATA[1:0]};
    end
  end

  // ----------------------------------------------------------------
  // fallback lock sequence
  // ----------------------------------------------------------------
  fallback_type fb_q;
  logic         fb_lock_ev;

  assign run[T_FB]  = (fb_q == FB_SEEN);
  assign fb_lock_ev = (fb_q == FB_WAIT) && !DOORS.door_l_open;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fb_q <= FB_IDLE;
    end else begin
      unique case (fb_q)
        FB_IDLE: begin
          if (DOORS.door_l_open && IGN_RUN && cockpit_lock_ev) begin
            fb_q <= FB_SEEN;
          end
        end
        FB_SEEN: begin
          if (done[T_FB]) begin
            fb_q <= FB_IDLE;
          end else if (!IGN_RUN) begin
            fb_q <= FB_WAIT;
          end
        end
        FB_WAIT: begin
          // a fresh ignition cycle abandons the sequence
          if (fb_lock_ev || IGN_RUN) begin
            fb_q <= FB_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // central_lock state
  // ----------------------------------------------------------------
  lock_state_type lk_q;
  logic           relock_q;
  logic           any_lock_ev;
  logic           cp_lock, cp_unlock;

  assign cp_lock   = cockpit_lock_ev && all_closed;
  assign cp_unlock = cockpit_unlock_ev && all_closed;
  assign run[T_RELOCK] = relock_q && !any_open;
  assign any_lock_ev = fob_lock_ev || cp_lock || fb_lock_ev || done[T_RELOCK]
                    || (speed_ev && ctrl_q[`CTRL_SPEED_BIT]);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lk_q <= '{drv: 1'b1, pas: 1'b1, flap: 1'b1, rear_en: 1'b0};
    end else if (crash_ev) begin
      lk_q <= '{drv: 1'b0, pas: 1'b0, flap: 1'b0, rear_en: lk_q.rear_en};
    end else if (cp_unlock) begin
      lk_q <= '{drv: 1'b0, pas: 1'b0, flap: 1'b0, rear_en: 1'b1};
    end else if (fob_unlock_ev && lk_q.drv) begin
      lk_q <= '{drv: 1'b0, pas: lk_q.pas, flap: 1'b0, rear_en: lk_q.rear_en};
    end else if (fob_unlock_ev) begin
      lk_q <= '{drv: 1'b0, pas: 1'b0, flap: 1'b0, rear_en: 1'b1};
    end else if (any_lock_ev) begin
      lk_q <= '{drv: 1'b1, pas: 1'b1, flap: 1'b1, rear_en: 1'b0};
    end else begin
      if (mech_ev) begin
        lk_q.drv <= 1'b0;
      end
      if (handle_l_ev) begin
        lk_q.drv <= 1'b0;
      end
      if (handle_r_ev) begin
        lk_q.pas <= 1'b0;
      end
      if ((mech_ev && SUPPLY_OK) || handle_l_ev || handle_r_ev) begin
        lk_q.flap <= 1'b0;
      end
    end
  end

  // relock only follows a deliberate unlock, and any door opening cancels it
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      relock_q <= 1'b0;
    end else if (any_open || any_lock_ev || crash_ev) begin
      relock_q <= 1'b0;
    end else if (fob_unlock_ev || cp_unlock) begin
      relock_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // actuator pulses
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACT <= '0;
    end else begin
      ACT.lock_all      <= any_lock_ev && !crash_ev && !cp_unlock && !fob_unlock_ev;
      ACT.unlock_drv    <= crash_ev || cp_unlock || fob_unlock_ev || mech_ev || handle_l_ev;
      ACT.unlock_pas    <= crash_ev || cp_unlock || (fob_unlock_ev && !lk_q.drv)
                        || handle_r_ev;
      ACT.unlock_flap   <= crash_ev || cp_unlock || fob_unlock_ev || handle_l_ev
                        || handle_r_ev || (mech_ev && SUPPLY_OK);
      ACT.trunk_release <= (fob_rear_ev && !ctrl_q[`CTRL_CABRIO_BIT])
                        || (rear_handle_ev && lk_q.rear_en);
      ACT.top_open      <= fob_top_ev && ctrl_q[`CTRL_CABRIO_BIT];
    end
  end

  // ----------------------------------------------------------------
  // theft_alarm
  // ----------------------------------------------------------------
  logic armed_q, alarm_q, excl_q, trigger, disarm_ev, interior_live;

  assign run[T_INT]    = armed_q;
  assign interior_live = done[T_INT] && !excl_q;
  assign disarm_ev     = fob_unlock_ev || (KEY_PRESENT && ign_on_ev);
  assign trigger = armed_q && ((DOORS.door_l_open != doors_q.door_l_open)
                 || (DOORS.door_r_open != doors_q.door_r_open)
                 || (DOORS.trunk_latch != doors_q.trunk_latch)
                 || (interior_live && (INTERIOR != interior_q))
                 || (!excl_q && (TILT != tilt_q))
                 || mech_ev);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      armed_q <= 1'b0;
    end else if (fob_lock_ev) begin
      armed_q <= 1'b1;
    end else if (disarm_ev) begin
      armed_q <= 1'b0;
    end
  end

  // a trigger in the disarming cycle still sounds
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      alarm_q <= 1'b0;
    end else if (trigger) begin
      alarm_q <= 1'b1;
    end else if (disarm_ev) begin
      alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      excl_q <= 1'b0;
    end else if (excl_ev) begin
      excl_q <= 1'b1;
    end else if (any_lock_ev) begin
      excl_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // key_a and lamps
  // ----------------------------------------------------------------
  logic key_a_q, flash_q, blink_q;

  assign run[T_KEY_A] = FOB.key_a && !key_a_q;
  assign run[T_FLASH] = (flash_q || alarm_q || key_a_q) && !done[T_FLASH];

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      key_a_q <= 1'b0;
    end else if (key_a_q && (ign_on_ev || key_a_ev)) begin
      key_a_q <= 1'b0;
    end else if (done[T_KEY_A]) begin
      key_a_q <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flash_q <= 1'b0;
      blink_q <= 1'b0;
    end else begin
      if (fob_unlock_ev) begin
        flash_q <= 1'b1;
      end else if (done[T_FLASH]) begin
        flash_q <= 1'b0;
      end
      if (!(alarm_q || key_a_q)) begin
        blink_q <= 1'b1;
      end else if (done[T_FLASH]) begin
        blink_q <= !blink_q;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SIREN     <= 1'b0;
      TURN_LAMP <= 1'b0;
    end else begin
      SIREN     <= alarm_q || key_a_q;
      TURN_LAMP <= (alarm_q || key_a_q) ? blink_q : flash_q;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] status;

  always_comb begin
    status = 32'h0000_0000;
    status[`ST_DRV_LOCKED]    = lk_q.drv;
    status[`ST_PAS_LOCKED]    = lk_q.pas;
    status[`ST_FLAP_LOCKED]   = lk_q.flap;
    status[`ST_REAR_EN]       = lk_q.rear_en;
    status[`ST_ARMED]         = armed_q;
    status[`ST_ALARM]         = alarm_q;
    status[`ST_KEY_A]         = key_a_q;
    status[`ST_INTERIOR_LIVE] = interior_live;
    status[`ST_EXCLUDED]      = excl_q;
    status[`ST_FALLBACK_LSB +: 2] = fb_q;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= (PADDR == `REG_CTRL)   ? ctrl_q :
                (PADDR == `REG_STATUS) ? status : 32'h0000_0000;
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
endmodule : door_lock_alarm_ctrl

/* sim/lock_motor_model.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------
// lock motors and latch motors seen from the controller pins
// --------------------------------------------------------------
module lock_motor_model (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire door_lock_pkg::act_type   act,
  output door_lock_pkg::lock_state_type pos,
  output logic [3:0]                    trunk_n,
  output logic [3:0]                    top_n
);
  import door_lock_pkg::*;
  // motors hold their last position; a lock pulse beats any unlock pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 4'hE;
    end else if (act.lock_all) begin
      pos <= 4'hE;
    end else begin
      if (act.unlock_drv) pos.drv <= 1'b0;
      if (act.unlock_pas) pos.pas <= 1'b0;
      if (act.unlock_flap) pos.flap <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trunk_n <= 4'h0;
      top_n   <= 4'h0;
    end else begin
      trunk_n <= trunk_n + 4'(act.trunk_release);
      top_n   <= top_n + 4'(act.top_open);
    end
  end
endmodule : lock_motor_model

/* sim/door_lock_alarm_ctrl_asserts.sv */
`timescale 1ns/1ps
module door_lock_alarm_ctrl_asserts (
  input wire logic                       REF_CLK,
  input wire logic                       RESETN,
  input wire logic                       PSEL,
  input wire logic                       PENABLE,
  input wire logic                       PWRITE,
  input wire logic [11:0]                PADDR,
  input wire logic [31:0]                PWDATA,
  input wire logic [3:0]                 PSTRB,
  input wire logic                       PREADY,
  input wire logic                       PSLVERR,
  input wire door_lock_pkg::fob_type     FOB,
  input wire door_lock_pkg::door_in_type DOORS,
  input wire logic                       LOCK_SW,
  input wire logic                       UNLOCK_SW,
  input wire logic                       MECH_KEY,
  input wire logic                       KEY_PRESENT,
  input wire logic                       IGN_RUN,
  input wire logic                       CRASH,
  input wire logic                       SUPPLY_OK,
  input wire logic [7:0]                 SPEED_KMH,
  input wire door_lock_pkg::act_type     ACT,
  input wire logic                       SIREN,
  input wire logic                       TURN_LAMP
);
  import door_lock_pkg::*;
  logic cab_q, spd_q, quiet, shut;
  // ctrl shadow rebuilt from bus writes, internals are not visible here
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cab_q <= 1'b0;
      spd_q <= 1'b1;
    end else if (PSEL && PENABLE && PWRITE && PADDR == 12'h000 && PSTRB[0]) begin
      cab_q <= PWDATA[1];
      spd_q <= PWDATA[0];
    end
  end
  // higher priority unlock sources would mask the event under test
  assign quiet = !UNLOCK_SW && !CRASH && !FOB.unlock;
  assign shut = !DOORS.door_l_open && !DOORS.door_r_open && !DOORS.rear_open;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  a_ready_high: assert property (PREADY) else $error("pready low");
  a_err_map: assert property (PSEL && PENABLE |->
    PSLVERR == (PADDR != 12'h000 && PADDR != 12'h004)) else $error("pslverr wrong");
  a_crash_open: assert property ($rose(CRASH) |-> ##[1:2] (ACT.unlock_drv && ACT.unlock_pas))
    else $error("crash did not unlock");
  a_cockpit_lock: assert property ($rose(LOCK_SW) && shut && quiet |-> ##[1:2] ACT.lock_all)
    else $error("cockpit lock missing");
  a_mech_key: assert property ($rose(MECH_KEY) && quiet && !LOCK_SW && !FOB.lock |->
    ##[1:2] (ACT.unlock_drv && (SUPPLY_OK || !ACT.unlock_flap))) else $error("mech key bad");
  a_speed_lock: assert property ($rose(IGN_RUN && SPEED_KMH > 8'h0E) && spd_q && quiet |->
    ##[1:2] ACT.lock_all) else $error("speed lock missing");
  a_rear_fob: assert property ($rose(FOB.rear) && FOB.auth && !cab_q |->
    ##[1:2] ACT.trunk_release) else $error("trunk not released");
  a_top_fob: assert property ($rose(FOB.top) && FOB.auth && cab_q |-> ##[1:2] ACT.top_open)
    else $error("top not opened");
  a_top_coupe: assert property ($rose(ACT.top_open) |-> cab_q) else $error("top on coupe");
  a_alarm_stop: assert property ($rose(IGN_RUN) && KEY_PRESENT && !FOB.key_a |->
    ##[1:3] !SIREN) else $error("siren kept on");
  a_alarm_lamp: assert property ($rose(SIREN) |-> ##[0:1] TURN_LAMP)
    else $error("lamps not flashing");
  a_fob_flash: assert property ($rose(FOB.unlock) && FOB.auth && !CRASH && !SIREN |->
    ##[1:3] TURN_LAMP) else $error("no unlock flash");
endmodule : door_lock_alarm_ctrl_asserts
bind door_lock_alarm_ctrl door_lock_alarm_ctrl_asserts u_door_lock_alarm_ctrl_asserts (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FOB(FOB), .DOORS(DOORS), .LOCK_SW(LOCK_SW), .UNLOCK_SW(UNLOCK_SW), .MECH_KEY(MECH_KEY),
  .KEY_PRESENT(KEY_PRESENT), .IGN_RUN(IGN_RUN), .CRASH(CRASH), .SUPPLY_OK(SUPPLY_OK),
  .SPEED_KMH(SPEED_KMH), .ACT(ACT), .SIREN(SIREN), .TURN_LAMP(TURN_LAMP));

/* sim/door_lock_alarm_ctrl_test.sv */
`timescale 1ns/1ps
`include "door_lock_map.svh"
module door_lock_alarm_ctrl_test;
  import door_lock_pkg::*;
  logic           REF_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [11:0]    PADDR;
  logic [31:0]    PWDATA, PRDATA, rd;
  logic [3:0]     PSTRB, trunk_n, top_n;
  logic [7:0]     SPEED_KMH;
  logic           LOCK_SW, UNLOCK_SW, EXCLUDE_SW, MECH_KEY, KEY_PRESENT, IGN_RUN, CRASH;
  logic           SUPPLY_OK, INTERIOR, TILT, SIREN, TURN_LAMP;
  fob_type        FOB;
  door_in_type    DOORS;
  act_type        ACT;
  lock_state_type pos;
  int             bad_count, n_checks, cycles;

  door_lock_alarm_ctrl #(.TICK_DIV(1)) u_door_lock_alarm_ctrl (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FOB(FOB), .DOORS(DOORS), .LOCK_SW(LOCK_SW), .UNLOCK_SW(UNLOCK_SW),
    .EXCLUDE_SW(EXCLUDE_SW), .MECH_KEY(MECH_KEY), .KEY_PRESENT(KEY_PRESENT),
    .IGN_RUN(IGN_RUN), .CRASH(CRASH), .SUPPLY_OK(SUPPLY_OK), .SPEED_KMH(SPEED_KMH),
    .INTERIOR(INTERIOR), .TILT(TILT), .ACT(ACT), .SIREN(SIREN), .TURN_LAMP(TURN_LAMP));
  lock_motor_model u_lock_motor_model (.clk(REF_CLK), .rst_n(RESETN), .act(ACT),
    .pos(pos), .trunk_n(trunk_n), .top_n(top_n));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : cyc
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d; PSTRB <= s;
    cyc(1);
    PENABLE <= 1'b1;
    do cyc(1); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    cyc(1);
  endtask : apb
  // 0 lock, 1 unlock, 2 mech key, 3 crash, 4 rear handle
  task press(input int w);
    case (w)
      0: LOCK_SW <= 1'b1;
      1: UNLOCK_SW <= 1'b1;
      2: MECH_KEY <= 1'b1;
      3: CRASH <= 1'b1;
      default: DOORS.rear_handle <= 1'b1;
    endcase
    cyc(2);
    LOCK_SW <= 1'b0; UNLOCK_SW <= 1'b0; MECH_KEY <= 1'b0; CRASH <= 1'b0;
    DOORS.rear_handle <= 1'b0;
    cyc(4);
  endtask : press
  task fob(input fob_type f);
    FOB <= f;
    cyc(2);
    FOB <= '0;
    cyc(4);
  endtask : fob
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // longest path is the relock wait plus two key_a holds
  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      bad_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB, FOB, DOORS} = '0;
    {LOCK_SW, UNLOCK_SW, EXCLUDE_SW, MECH_KEY, KEY_PRESENT, IGN_RUN, CRASH} = '0;
    {INTERIOR, TILT, SPEED_KMH, cycles, bad_count, n_checks} = '0;
    SUPPLY_OK = 1'b1;
    RESETN = 1'b0;
    cyc(5);
    RESETN <= 1'b1;
    apb(0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h0000_0001);
    apb(0, 12'h008, 32'h0, 4'h0); chk({rd[30:0], err}, 32'h0000_0001);
    apb(1, 12'h000, 32'h0, 4'h0); apb(0, 12'h000, 32'h0, 4'h0); chk(rd, 32'h0000_0001);
    apb(1, 12'h004, 32'h0, 4'hF); apb(0, 12'h004, 32'h0, 4'h0);
    chk(rd & 32'h0000_001F, 32'h0000_0007);
    DOORS <= 7'h20; press(1); chk(32'(pos.drv), 32'h1);
    DOORS <= 7'h00; press(1); chk(32'(pos[3:1]), 32'h0);
    apb(0, 12'h004, 32'h0, 4'h0); chk(32'(rd[`ST_REAR_EN]), 32'h1);
    press(0); chk(32'(pos[3:1]), 32'h7);
    fob(6'h30); apb(0, 12'h004, 32'h0, 4'h0); chk(32'(rd[`ST_ARMED]), 32'h1);
    fob(6'h28); chk(32'({pos[3:1], TURN_LAMP}), 32'h5);
    apb(0, 12'h004, 32'h0, 4'h0); chk(32'(rd[`ST_ARMED]), 32'h0);
    fob(6'h28); chk(32'(pos[3:1]), 32'h0);
    press(4); chk(32'(trunk_n), 32'h1);
    fob(6'h24); fob(6'h04); chk(32'(trunk_n), 32'h2);
    fob(6'h22); chk(32'(top_n), 32'h0);
    apb(1, 12'h000, 32'h0000_0003, 4'h1);
    fob(6'h22); fob(6'h24); chk(32'({trunk_n, top_n}), 32'h21);
    press(0); press(1);
    IGN_RUN <= 1'b1; SPEED_KMH <= 8'h0E; cyc(5); chk(32'(pos.drv), 32'h0);
    SPEED_KMH <= 8'h0F; cyc(5); chk(32'(pos[3:1]), 32'h7);
    IGN_RUN <= 1'b0; SPEED_KMH <= 8'h00;
    fob(6'h30); DOORS <= 7'h40; cyc(5); chk(32'(SIREN), 32'h1);
    KEY_PRESENT <= 1'b1; IGN_RUN <= 1'b1; cyc(5);
    apb(0, 12'h004, 32'h0, 4'h0); chk(32'({rd[`ST_ARMED], SIREN}), 32'h0);
    IGN_RUN <= 1'b0; KEY_PRESENT <= 1'b0; DOORS <= 7'h00;
    FOB <= 6'h01; cyc(990); chk(32'(SIREN), 32'h0);
    cyc(20); chk(32'({SIREN, TURN_LAMP}), 32'h3);
    IGN_RUN <= 1'b1; cyc(5); chk(32'(SIREN), 32'h0);
    FOB <= 6'h00; IGN_RUN <= 1'b0; cyc(2);
    FOB <= 6'h01; cyc(1010); chk(32'(SIREN), 32'h1);
    FOB <= 6'h00; cyc(2); FOB <= 6'h01; cyc(5); chk(32'(SIREN), 32'h0);
    FOB <= 6'h00;
    press(3); chk(32'(pos[3:2]), 32'h0);
    DOORS <= 7'h40; IGN_RUN <= 1'b1; cyc(3); press(0); IGN_RUN <= 1'b0; cyc(5);
    DOORS <= 7'h00; cyc(5); chk(32'(pos[3:2]), 32'h3);
    fob(6'h30); SUPPLY_OK <= 1'b0; press(2);
    chk(32'({pos.drv, pos.flap, SIREN}), 32'h3);
    fob(6'h28); chk(32'(SIREN), 32'h0);
    SUPPLY_OK <= 1'b1;
    press(0); press(1); cyc(59980); chk(32'(pos.drv), 32'h0);
    cyc(40); chk(32'(pos[3:1]), 32'h7);
    conclude();
  end
endmodule : door_lock_alarm_ctrl_test
